// *** sfpi_pkg.sv ***
// Shared constants and types of the serial flash pin front end
package sfpi_pkg;
	// Data path
	localparam int SFPI_DATA_W = 8;
	localparam int SFPI_BUF_DEPTH = 2;
	localparam int SFPI_CNT_W = 3;
	localparam int SFPI_LANES = 4;
	localparam int SFPI_SYNC_W = 6;

	// Lane positions on the pin vector
	localparam int SFPI_LANE_SI = 0;
	localparam int SFPI_LANE_SO = 1;
	localparam int SFPI_LANE_WP = 2;
	localparam int SFPI_LANE_PAUSE = 3;

	// Positions of the pin inputs inside the synchroniser vector
	localparam int SFPI_SYNC_SCLK = 4;
	localparam int SFPI_SYNC_CS = 5;

	// Lane-3 function select values
	localparam logic SFPI_LANE3_PAUSE = 1'b0;
	localparam logic SFPI_LANE3_RESET = 1'b1;

	// Output enables per lane mode
	localparam logic [3:0] SFPI_OE_SINGLE = 4'h2;
	localparam logic [3:0] SFPI_OE_DUAL = 4'h3;
	localparam logic [3:0] SFPI_OE_QUAD = 4'hf;
	localparam logic [3:0] SFPI_OE_NONE = 4'h0;

	// Values after reset and idle fill
	localparam logic [3:0] SFPI_LANE_RST = 4'h0;
	localparam logic [7:0] SFPI_TX_FILL = 8'hff;
	localparam logic [7:0] SFPI_BYTE_RST = 8'h00;
	localparam logic [2:0] SFPI_CNT_RST = 3'h0;

	// Hardware reset recognition time
	localparam int SFPI_CLK_PERIOD_NS = 20;
	localparam int SFPI_T_RESET_NS = 1000;
	localparam int SFPI_RESET_CYCLES = (SFPI_T_RESET_NS + SFPI_CLK_PERIOD_NS - 1) / SFPI_CLK_PERIOD_NS;
	localparam int SFPI_RST_CNT_W = 6;
	localparam logic [5:0] SFPI_RST_CNT_MAX = 6'(SFPI_RESET_CYCLES);
	localparam logic [5:0] SFPI_RST_CNT_RST = 6'h00;

	typedef enum logic [1:0] {SFPI_MODE_SINGLE, SFPI_MODE_DUAL, SFPI_MODE_QUAD} sfpi_mode_t;
endpackage

// *** sfpi_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sfpi_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	import sfpi_pkg::*;

	logic [W-1:0] meta_reg;

	// First stage is read by the second stage only
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			meta_reg <= '0;
			sync_o <= '0;
		end
		else if (ce_i)
		begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
endmodule // sfpi_sync

// *** sfpi_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module sfpi_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Fill side
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// Drain side
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	import sfpi_pkg::*;

	logic [W-1:0] mem_reg [DEPTH];
	logic [1:0] count_reg;
	logic [1:0] count_next;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	wire full = (count_reg == 2'(DEPTH));

	// Entry 0 is always the head, so the read data leave a register
	assign out_data_o = mem_reg[0];
	assign in_ready_o = !full;
	assign count_next = count_reg + 2'(push) - 2'(pop);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			count_reg <= 2'h0;
			out_valid_o <= 1'b0;
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
		end
		else if (ce_i)
		begin
			count_reg <= count_next;
			out_valid_o <= (count_next != 2'h0);
			if (pop)
				mem_reg[0] <= (push && count_reg == 2'h1) ? in_data_i : mem_reg[1];
			else if (push && count_reg == 2'h0)
				mem_reg[0] <= in_data_i;
			if (push && (count_reg == 2'h2 || (count_reg == 2'h1 && !pop)))
				mem_reg[1] <= in_data_i;
		end
endmodule // sfpi_buf

// *** sfpi_pins.sv ***
// Pin-level front end of a serial NOR flash slave
`timescale 1ns/10ps
module sfpi_pins (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Flash pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_lane_i,
	output logic [3:0] io_lane_o,
	output logic [3:0] io_lane_oe_o,
	// Configuration
	input wire logic quad_enable_i,
	input wire logic hold_or_reset_select_i,
	input wire logic status_protect_i,
	// Command side control
	input wire sfpi_pkg::sfpi_mode_t lane_mode_i,
	input wire logic drive_out_i,
	// Received bytes
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	// Bytes to send
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// Status
	output logic selected_o,
	output logic frame_start_o,
	output logic frame_end_o,
	output logic paused_o,
	output logic cmd_block_o,
	output logic hw_reset_o,
	output logic status_wr_block_o,
	output logic quad_reject_o,
	output logic rx_overrun_o
);
	import sfpi_pkg::*;

	// Bits moved per clock in each lane mode
	function automatic logic [2:0] lane_width(input sfpi_mode_t m);
		unique case (m)
			SFPI_MODE_SINGLE: lane_width = 3'h1;
			SFPI_MODE_DUAL: lane_width = 3'h2;
			SFPI_MODE_QUAD: lane_width = 3'h4;
			default: lane_width = 3'h1;
		endcase
	endfunction

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic [SFPI_SYNC_W-1:0] sync_s;
	logic sclk_d_reg;
	logic cs_d_reg;
	logic armed_reg;
	logic sel_reg;
	logic paused_reg;
	logic [SFPI_RST_CNT_W-1:0] rst_cnt_reg;
	logic [SFPI_RST_CNT_W-1:0] rst_cnt_next;
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;
	logic [7:0] rx_sh_reg;
	logic [7:0] rx_sh_next;
	logic [7:0] tx_sh_reg;
	logic [7:0] tx_sh_next;
	logic [3:0] lane_out_next;
	logic [3:0] oe_next;
	logic [7:0] pend_data_reg;
	logic pend_valid_reg;
	logic buf_in_ready;
	logic [7:0] buf_data;
	logic buf_valid;
	sfpi_mode_t mode_eff;

	// Reset release through two flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end

	sfpi_sync #(
		.W(SFPI_SYNC_W)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_sync_reg),
		.ce_i(ce_i),
		.async_i({cs_n_i, sclk_i, io_lane_i}),
		.sync_o(sync_s)
	);

	wire [3:0] lane_s = sync_s[SFPI_LANES-1:0];
	wire sclk_s = sync_s[SFPI_SYNC_SCLK];
	wire cs_n_s = sync_s[SFPI_SYNC_CS];
	wire sclk_rise = sclk_s && !sclk_d_reg;
	wire sclk_fall = !sclk_s && sclk_d_reg;
	wire cs_fall = !cs_n_s && cs_d_reg;
	wire cs_rise = cs_n_s && !cs_d_reg;
	// Frame opens only once select was seen high since reset
	wire frame_open = cs_fall && armed_reg;

	// Pin roles follow quad_enable and the lane-3 select bit
	wire quad_req = (lane_mode_i == SFPI_MODE_QUAD);
	wire quad_bad = quad_req && !quad_enable_i;
	wire pin_fn_ok = !quad_enable_i;
	wire pause_fn = pin_fn_ok && (hold_or_reset_select_i == SFPI_LANE3_PAUSE);
	wire reset_fn = pin_fn_ok && (hold_or_reset_select_i == SFPI_LANE3_RESET);
	wire reset_low = reset_fn && !lane_s[SFPI_LANE_PAUSE];
	wire wp_low = pin_fn_ok && !lane_s[SFPI_LANE_WP];
	wire pause_req = pause_fn && !lane_s[SFPI_LANE_PAUSE] && sel_reg;
	// Pause state follows the pin only while the serial clock is low
	wire pause_move = (pause_req != paused_reg) && !sclk_s;

	// A refused quad request falls back to single lane use
	assign mode_eff = quad_bad ? SFPI_MODE_SINGLE : lane_mode_i;
	wire [2:0] width = lane_width(mode_eff);
	wire active = sel_reg && !paused_reg && !reset_low;
	wire take_bit = active && sclk_rise && !drive_out_i;
	wire give_bit = active && sclk_fall && drive_out_i;

	// Inbound shift, lane 1 or 3 holds the earlier bit
	wire [7:0] rx_sh1 = {rx_sh_reg[6:0], lane_s[SFPI_LANE_SI]};
	wire [7:0] rx_sh2 = {rx_sh_reg[5:0], lane_s[1:0]};
	wire [7:0] rx_sh4 = {rx_sh_reg[3:0], lane_s[3:0]};
	assign rx_sh_next = (width == 3'h4) ? rx_sh4 : (width == 3'h2) ? rx_sh2 : rx_sh1;

	// Widths 1, 2 and 4 all divide a byte, so the count wraps to zero
	assign bit_cnt_next = bit_cnt_reg + width;
	wire byte_done = (bit_cnt_next == SFPI_CNT_RST);
	wire rx_byte = take_bit && byte_done;

	// Outbound shift; a new byte is fetched at each byte boundary
	wire tx_fetch = give_bit && (bit_cnt_reg == SFPI_CNT_RST);
	wire [7:0] tx_word = tx_valid_i ? tx_data_i : SFPI_TX_FILL;
	wire [7:0] tx_src = (bit_cnt_reg == SFPI_CNT_RST) ? tx_word : tx_sh_reg;
	assign tx_sh_next = tx_src << width;
	wire [3:0] lane_single = {2'h0, tx_src[7], 1'b0};
	wire [3:0] lane_dual = {2'h0, tx_src[7:6]};
	wire [3:0] lane_quad = tx_src[7:4];
	assign lane_out_next = (width == 3'h4) ? lane_quad : (width == 3'h2) ? lane_dual : lane_single;

	// Lanes are driven only while selected, unpaused and sending
	wire [3:0] oe_mode = (width == 3'h4) ? SFPI_OE_QUAD : (width == 3'h2) ? SFPI_OE_DUAL : SFPI_OE_SINGLE;
	assign oe_next = (active && drive_out_i && !cs_n_s) ? oe_mode : SFPI_OE_NONE;

	// A byte waits here until the buffer takes it; the next byte may not
	wire pend_take = pend_valid_reg && buf_in_ready;
	wire overrun_evt = rx_byte && pend_valid_reg && !buf_in_ready;

	// Reset pin low time counter
	wire rst_cnt_full = (rst_cnt_reg == SFPI_RST_CNT_MAX);
	assign rst_cnt_next = !reset_low ? SFPI_RST_CNT_RST : rst_cnt_full ? rst_cnt_reg : rst_cnt_reg + 6'h01;

	// Frame and pause control
	always_ff @(posedge clk_sys_i or negedge rst_sync_reg)
		if (!rst_sync_reg)
		begin
			sclk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
			armed_reg <= 1'b0;
			sel_reg <= 1'b0;
			paused_reg <= 1'b0;
			frame_start_o <= 1'b0;
			frame_end_o <= 1'b0;
		end
		else if (ce_i)
		begin
			sclk_d_reg <= sclk_s;
			cs_d_reg <= cs_n_s;
			if (cs_n_s)
				armed_reg <= 1'b1;
			frame_start_o <= frame_open;
			frame_end_o <= cs_rise && sel_reg;
			if (frame_open)
				sel_reg <= 1'b1;
			else if (cs_rise)
				sel_reg <= 1'b0;
			// Deselect during a pause drops the pause with the frame
			if (!sel_reg || cs_n_s)
				paused_reg <= 1'b0;
			else if (pause_move)
				paused_reg <= pause_req;
		end

	// Shift state; frozen but kept while paused
	always_ff @(posedge clk_sys_i or negedge rst_sync_reg)
		if (!rst_sync_reg)
		begin
			bit_cnt_reg <= SFPI_CNT_RST;
			rx_sh_reg <= SFPI_BYTE_RST;
			tx_sh_reg <= SFPI_BYTE_RST;
			io_lane_o <= SFPI_LANE_RST;
			tx_ready_o <= 1'b0;
		end
		else if (ce_i)
		begin
			tx_ready_o <= tx_fetch && tx_valid_i;
			if (cs_rise || frame_open)
			begin
				bit_cnt_reg <= SFPI_CNT_RST;
				rx_sh_reg <= SFPI_BYTE_RST;
				tx_sh_reg <= SFPI_BYTE_RST;
			end
			else if (take_bit)
			begin
				bit_cnt_reg <= bit_cnt_next;
				rx_sh_reg <= rx_sh_next;
			end
			else if (give_bit)
			begin
				bit_cnt_reg <= bit_cnt_next;
				tx_sh_reg <= tx_sh_next;
				io_lane_o <= lane_out_next;
			end
		end

	// Received byte holding stage
	always_ff @(posedge clk_sys_i or negedge rst_sync_reg)
		if (!rst_sync_reg)
		begin
			pend_data_reg <= SFPI_BYTE_RST;
			pend_valid_reg <= 1'b0;
			rx_overrun_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (rx_byte && (!pend_valid_reg || buf_in_ready))
			begin
				pend_data_reg <= rx_sh_next;
				pend_valid_reg <= 1'b1;
			end
			else if (pend_take)
				pend_valid_reg <= 1'b0;
			// Set wins over the clear at a new frame
			if (overrun_evt)
				rx_overrun_o <= 1'b1;
			else if (frame_open)
				rx_overrun_o <= 1'b0;
		end

	// Status outputs and lane enables
	always_ff @(posedge clk_sys_i or negedge rst_sync_reg)
		if (!rst_sync_reg)
		begin
			io_lane_oe_o <= SFPI_OE_NONE;
			selected_o <= 1'b0;
			paused_o <= 1'b0;
			cmd_block_o <= 1'b0;
			hw_reset_o <= 1'b0;
			status_wr_block_o <= 1'b0;
			quad_reject_o <= 1'b0;
			rst_cnt_reg <= SFPI_RST_CNT_RST;
		end
		else if (ce_i)
		begin
			io_lane_oe_o <= oe_next;
			selected_o <= sel_reg;
			paused_o <= paused_reg;
			rst_cnt_reg <= rst_cnt_next;
			cmd_block_o <= reset_low;
			hw_reset_o <= reset_low && rst_cnt_full;
			status_wr_block_o <= wp_low && status_protect_i;
			quad_reject_o <= quad_bad;
		end

	sfpi_buf #(
		.W(SFPI_DATA_W),
		.DEPTH(SFPI_BUF_DEPTH)
	) u_rx_buf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_sync_reg),
		.ce_i(ce_i),
		.in_data_i(pend_data_reg),
		.in_valid_i(pend_valid_reg),
		.in_ready_o(buf_in_ready),
		.out_data_o(buf_data),
		.out_valid_o(buf_valid),
		.out_ready_i(rx_ready_i)
	);

	assign rx_data_o = buf_data;
	assign rx_valid_o = buf_valid;
endmodule // sfpi_pins

// *** sfpi_pins_assertions.sv ***
// Concurrent checks on the ports of the pin front end
`timescale 1ns/10ps
module sfpi_pins_assertions (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Pins and configuration
	input wire logic cs_n_i,
	input wire logic [3:0] io_lane_i,
	input wire logic [3:0] io_lane_oe_o,
	input wire logic quad_enable_i,
	input wire logic hold_or_reset_select_i,
	input wire logic status_protect_i,
	input wire sfpi_pkg::sfpi_mode_t lane_mode_i,
	// Stream and status
	input wire logic [7:0] rx_data_o,
	input wire logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic selected_o,
	input wire logic frame_end_o,
	input wire logic paused_o,
	input wire logic cmd_block_o,
	input wire logic hw_reset_o,
	input wire logic status_wr_block_o,
	input wire logic quad_reject_o,
	input wire logic rx_overrun_o
);
	import sfpi_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Pin inputs pass a synchroniser, so causes must stand a few cycles
	a_desel_tristate: assert property (cs_n_i [*5] |-> io_lane_oe_o == SFPI_OE_NONE)
		else $error("lanes driven while deselected");
	a_quad_lanes_gated: assert property (!quad_enable_i [*3] |-> io_lane_oe_o[3:2] == 2'h0)
		else $error("upper lanes driven without quad enable");
	a_quad_reject_flag: assert property ((lane_mode_i == SFPI_MODE_QUAD && !quad_enable_i) [*2] |-> quad_reject_o)
		else $error("quad request not refused");
	a_wp_blocks_status: assert property ((status_protect_i && !quad_enable_i && !io_lane_i[2]) [*8]
		|-> status_wr_block_o)
		else $error("status write not blocked");
	a_wp_off_quad: assert property (quad_enable_i [*3] |-> !status_wr_block_o)
		else $error("write protect active in quad");
	a_pause_tristate: assert property (paused_o [*2] |-> io_lane_oe_o == SFPI_OE_NONE)
		else $error("lanes driven while paused");
	a_pause_needs_hold: assert property ((hold_or_reset_select_i || quad_enable_i || cs_n_i) [*8] |-> !paused_o)
		else $error("pause without pause function");
	a_reset_pin_blocks: assert property ((hold_or_reset_select_i && !quad_enable_i && !io_lane_i[3]) [*8]
		|-> cmd_block_o)
		else $error("commands not blocked by reset pin");
	a_reset_pin_time: assert property ($rose(cmd_block_o) |-> !hw_reset_o [*8])
		else $error("hardware reset too early");
	a_frame_end_seen: assert property ((selected_o && $rose(cs_n_i)) |-> ##[1:6] frame_end_o)
		else $error("frame end missing");
	a_rx_word_held: assert property ((rx_valid_o && !rx_ready_i) |=> (rx_valid_o && $stable(rx_data_o)))
		else $error("received byte lost while stalled");
	c_frame_end: cover property (frame_end_o);
	c_paused: cover property (paused_o);
	c_hw_reset: cover property (hw_reset_o);
	c_overrun: cover property (rx_overrun_o);
endmodule // sfpi_pins_assertions

// *** sfpi_host_model.sv ***
// Host controller model: serial clock, select and data lanes
`timescale 1ns/10ps
module sfpi_host_model (
	// Lanes as seen on the wire
	input wire logic [3:0] lane_i,
	// Host pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] d_o,
	output logic [3:0] oe_o
);
	initial
	begin
		sclk_o = 1'b0; // Mode 0, idle low between frames
		cs_n_o = 1'b0; // Low from power-up: no select edge yet
		d_o = 4'h0;
		oe_o = 4'h0;
	end
	task automatic begin_frame();
		#80 cs_n_o = 1'b0;
		#80;
	endtask
	task automatic end_frame();
		#80 cs_n_o = 1'b1;
		#160;
	endtask
	// One byte, MSB first; reads sample just before the next fall
	task automatic xfer(input logic [7:0] tx, input int n, input bit rd, output logic [7:0] rx);
		logic [3:0] m;
		m = (n == 4) ? 4'hf : (n == 2) ? 4'h3 : 4'h1;
		oe_o = rd ? 4'h0 : m;
		rx = 8'h00;
		if (rd)
		begin
			#80 sclk_o = 1'b1;
			#80 sclk_o = 1'b0;
		end
		for (int s = 0; s < 8 / n; s++)
		begin
			d_o = 4'(tx >> (8 - n * (s + 1))) & m; // Changed while clock low
			#80 sclk_o = 1'b1;
			#79 rx = (rx << n) | 8'(((n == 1) ? lane_i >> 1 : lane_i) & m);
			#1 sclk_o = 1'b0;
		end
		oe_o = 4'h0;
	endtask
endmodule // sfpi_host_model

// *** tb_top.sv ***
// Self-checking bench for the serial flash pin front end
`timescale 1ns/10ps
module tb_top;
	import sfpi_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic idle_pat = 1'b0;
	logic wp_n = 1'b1;
	logic pause_n = 1'b1;
	logic qe = 1'b0;
	logic hrs = 1'b0;
	logic sp = 1'b0;
	logic drive_out = 1'b0;
	logic rx_ready = 1'b1;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	sfpi_mode_t mode = SFPI_MODE_SINGLE;
	logic sclk, cs_n, rx_valid, tx_rdy, sel, fs, fe, paused, cblk, hwr, swb, qrej, ovr;
	logic [3:0] h_d, h_oe, d_o, d_oe, lane_w, eoe;
	logic [7:0] rx_data, got, b;
	logic [7:0] rxq[$];
	int num_errors = 0;
	int compares = 0;
	int seed = 21893;
	int n;
	int fs_cnt = 0;
	int fe_cnt = 0;
	int txr_cnt = 0;
	int nrd = 0;
	logic ce = 1'b1;
	bit rd;
	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		idle_pat <= ~idle_pat;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back(rx_data);
		if (fs === 1'b1)
			fs_cnt++;
		if (fe === 1'b1)
			fe_cnt++;
		if (tx_rdy === 1'b1)
			txr_cnt++;
	end
	// Undriven data lanes toggle; control pins held by the bench
	assign lane_w = (d_oe & d_o) | (~d_oe & h_oe & h_d) | (~d_oe & ~h_oe & {pause_n, wp_n, idle_pat, idle_pat});
	sfpi_host_model u_sfpi_host_model (.lane_i(lane_w), .sclk_o(sclk), .cs_n_o(cs_n), .d_o(h_d), .oe_o(h_oe));
	sfpi_pins u_sfpi_pins (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .sclk_i(sclk),
		.cs_n_i(cs_n), .io_lane_i(lane_w), .io_lane_o(d_o), .io_lane_oe_o(d_oe), .quad_enable_i(qe),
		.hold_or_reset_select_i(hrs), .status_protect_i(sp), .lane_mode_i(mode), .drive_out_i(drive_out),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_rdy), .selected_o(sel), .frame_start_o(fs), .frame_end_o(fe),
		.paused_o(paused), .cmd_block_o(cblk), .hw_reset_o(hwr), .status_wr_block_o(swb),
		.quad_reject_o(qrej), .rx_overrun_o(ovr));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask
	// Refused quad falls back to one lane
	function automatic int exp_width(input sfpi_mode_t m, input logic q);
		return (m == SFPI_MODE_QUAD && q) ? 4 : (m == SFPI_MODE_DUAL) ? 2 : 1;
	endfunction
	function automatic logic [3:0] exp_oe(input int w);
		return (w == 4) ? SFPI_OE_QUAD : (w == 2) ? SFPI_OE_DUAL : SFPI_OE_SINGLE;
	endfunction
	task automatic pop(input logic [7:0] e);
		for (int t = 0; t < 200 && rxq.size() == 0; t++)
			cyc(1);
		got = (rxq.size() > 0) ? rxq.pop_front() : 8'hxx;
		chk(got, e);
	endtask
	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		cyc(16);
		rst_n_i = 1'b1;
		cyc(4);
		u_sfpi_host_model.xfer(8'h5a, 1, 1'b0, got);
		cyc(10);
		chk({7'h0, sel}, 8'h00);
		chk(8'(rxq.size()), 8'h00);
		u_sfpi_host_model.end_frame();
		repeat (10)
		begin
			cyc(1);
			b = 8'($random(seed));
			mode = sfpi_mode_t'($unsigned($random(seed)) % 3);
			qe = 1'($random(seed));
			rd = 1'($random(seed));
			n = exp_width(mode, qe);
			eoe = exp_oe(n);
			nrd = nrd + int'(rd);
			drive_out = rd;
			tx_data = b;
			tx_valid = rd;
			cyc(2);
			u_sfpi_host_model.begin_frame();
			u_sfpi_host_model.xfer(b, n, rd, got);
			chk({7'h0, qrej}, {7'h0, mode == SFPI_MODE_QUAD && !qe});
			chk({7'h0, sel}, 8'h01);
			if (rd)
			begin
				chk(got, b);
				chk({4'h0, d_oe}, {4'h0, eoe});
			end
			u_sfpi_host_model.end_frame();
			if (!rd)
				pop(b);
			cyc(6);
			chk({4'h0, d_oe}, 8'h00);
			tx_valid = 1'b0;
		end
		qe = 1'b0;
		mode = SFPI_MODE_SINGLE;
		drive_out = 1'b0;
		u_sfpi_host_model.begin_frame();
		cyc(1);
		pause_n = 1'b0; // Select kept low through the pause
		cyc(8);
		chk({7'h0, paused}, 8'h01);
		u_sfpi_host_model.xfer(8'hc3, 1, 1'b0, got);
		cyc(1);
		pause_n = 1'b1;
		cyc(8);
		u_sfpi_host_model.xfer(8'h3c, 1, 1'b0, got);
		u_sfpi_host_model.end_frame();
		pop(8'h3c);
		rx_ready = 1'b0;
		u_sfpi_host_model.begin_frame();
		for (int i = 0; i < 4; i++)
			u_sfpi_host_model.xfer(8'h10 + 8'(i), 1, 1'b0, got);
		u_sfpi_host_model.end_frame();
		cyc(1);
		chk({7'h0, ovr}, 8'h01);
		rx_ready = 1'b1;
		for (int i = 0; i < 3; i++)
			pop(8'h10 + 8'(i));
		sp = 1'b1;
		wp_n = 1'b0;
		cyc(8);
		chk({7'h0, swb}, 8'h01);
		qe = 1'b1;
		cyc(8);
		chk({7'h0, swb}, 8'h00);
		qe = 1'b0;
		wp_n = 1'b1;
		hrs = 1'b1;
		pause_n = 1'b0; // Held well beyond the reset time
		cyc(8);
		chk({7'h0, cblk}, 8'h01);
		chk({7'h0, hwr}, 8'h00);
		u_sfpi_host_model.begin_frame();
		u_sfpi_host_model.xfer(8'h77, 1, 1'b0, got);
		u_sfpi_host_model.end_frame();
		cyc(10);
		chk({7'h0, hwr}, 8'h01);
		chk(8'(rxq.size()), 8'h00);
		// Enable low must hide the pin release from all state
		ce = 1'b0;
		pause_n = 1'b1;
		cyc(8);
		chk({7'h0, hwr}, 8'h01);
		ce = 1'b1;
		cyc(8);
		chk({7'h0, hwr}, 8'h00);
		hrs = 1'b0;
		cyc(4);
		// Thirteen armed frames; each read fetches at its first and last fall
		chk(8'(fs_cnt), 8'h0d);
		chk(8'(fe_cnt), 8'h0d);
		chk(8'(txr_cnt), 8'(2 * nrd));
		end_of_test();
	end
	initial
	begin
		#1000000;
		num_errors++;
		end_of_test();
	end
endmodule // tb_top
bind sfpi_pins sfpi_pins_assertions u_sfpi_pins_assertions (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.cs_n_i(cs_n_i), .io_lane_i(io_lane_i), .io_lane_oe_o(io_lane_oe_o), .quad_enable_i(quad_enable_i),
	.hold_or_reset_select_i(hold_or_reset_select_i), .status_protect_i(status_protect_i),
	.lane_mode_i(lane_mode_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
	.selected_o(selected_o), .frame_end_o(frame_end_o), .paused_o(paused_o), .cmd_block_o(cmd_block_o),
	.hw_reset_o(hw_reset_o), .status_wr_block_o(status_wr_block_o), .quad_reject_o(quad_reject_o),
	.rx_overrun_o(rx_overrun_o));
